/* core/pad_io_register_cell.sv */
// one general-purpose pad cell with its register port
`timescale 1ns/1ps
`default_nettype none
`include "pad_io_map.svh"

module pad_io_register_cell
  import pad_io_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 32
) (
  input  wire logic              ref_clk_in,
  input  wire logic              rstn_in,
  input  wire logic [ADDR_W-1:0] bus_addr_in,
  input  wire logic [DATA_W-1:0] bus_wdata_in,
  input  wire logic              bus_write_in,
  input  wire logic              bus_read_in,
  output logic      [DATA_W-1:0] bus_rdata_out,
  input  wire logic              configuring_in,
  input  wire logic              capture_clock_in,
  input  wire logic              launch_clock_in,
  input  wire logic              clock_tree_in,
  input  wire logic [1:0]        core_out_in,
  input  wire logic              core_oe_in,
  output logic      [1:0]        core_in_out,
  output logic                   bypass_path_out,
  input  wire logic              pad_in,
  output logic                   pad_out,
  output logic                   pad_oe_out,
  output logic                   pull_up_out,
  output logic                   pull_down_out
);

  ////////////////////////////////////////////////////////////////////////
  // reset release

  logic rst_sync1;
  logic rst_n;

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_sync1 <= 1'b0;
      rst_n     <= 1'b0;
    end else begin
      rst_sync1 <= 1'b1;
      rst_n     <= rst_sync1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register port

  logic [`PIO_CTRL_WIDTH-1:0] ctrl;
  logic [`PIO_STAT_WIDTH-1:0] status;

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `PIO_CTRL_RESET;
    end else if (bus_write_in && bus_addr_in == `PIO_CTRL_ADDR) begin
      ctrl <= bus_wdata_in[`PIO_CTRL_WIDTH-1:0];
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata_out <= '0;
    end else if (bus_read_in && bus_addr_in == `PIO_CTRL_ADDR) begin
      bus_rdata_out <= {{(DATA_W-`PIO_CTRL_WIDTH){1'b0}}, ctrl};
    end else if (bus_read_in && bus_addr_in == `PIO_STAT_ADDR) begin
      bus_rdata_out <= {{(DATA_W-`PIO_STAT_WIDTH){1'b0}}, status};
    end else begin
      bus_rdata_out <= '0;
    end
  end

  pad_mode_e mode;
  logic      in_reg;
  logic      in_fall;
  logic      out_reg;
  logic      out_fall;
  logic      oe_reg;
  logic      oe_fall;
  logic      invert;
  logic      dual_edge_io_in;
  logic      dual_edge_io_out;
  logic      resync;
  logic      bypass;
  logic      pd_sel;
  logic      diff_pair;
  logic      pin_used;

  assign mode      = pad_mode_e'(ctrl[`PIO_MODE_MSB:`PIO_MODE_LSB]);
  assign in_reg    = ctrl[`PIO_IN_REG_BIT];
  assign in_fall   = ctrl[`PIO_IN_FALL_BIT];
  assign out_reg   = ctrl[`PIO_OUT_REG_BIT];
  assign out_fall  = ctrl[`PIO_OUT_FALL_BIT];
  assign oe_reg    = ctrl[`PIO_OE_REG_BIT];
  assign oe_fall   = ctrl[`PIO_OE_FALL_BIT];
  assign invert    = ctrl[`PIO_INVERT_BIT];
  assign dual_edge_io_in   = ctrl[`PIO_DUAL_EDGE_IO_IN_BIT];
  assign dual_edge_io_out  = ctrl[`PIO_DUAL_EDGE_IO_OUT_BIT];
  assign resync    = ctrl[`PIO_RESYNC_BIT];
  assign bypass    = ctrl[`PIO_BYPASS_BIT];
  assign pd_sel    = ctrl[`PIO_PULL_DOWN_BIT];
  assign diff_pair = ctrl[`PIO_DIFF_PAIR_BIT];
  assign pin_used  = ctrl[`PIO_USED_BIT];

  assign status = {configuring_in, pad_out, pad_oe_out, core_in_out, pad_in};

  ////////////////////////////////////////////////////////////////////////
  // capture and launch clock edges

  logic cap_prev;
  logic lau_prev;
  logic cap_rise;
  logic cap_fall;
  logic lau_rise;
  logic lau_fall;

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      cap_prev <= 1'b0;
      lau_prev <= 1'b0;
    end else begin
      cap_prev <= capture_clock_in;
      lau_prev <= launch_clock_in;
    end
  end

  assign cap_rise = capture_clock_in && !cap_prev;
  assign cap_fall = !capture_clock_in && cap_prev;
  assign lau_rise = launch_clock_in && !lau_prev;
  assign lau_fall = !launch_clock_in && lau_prev;

  logic in_hit;
  logic out_hit;
  logic oe_hit;

  assign in_hit  = pick_edge(cap_rise, cap_fall, in_fall);
  assign out_hit = pick_edge(lau_rise, lau_fall, out_fall);
  assign oe_hit  = pick_edge(lau_rise, lau_fall, oe_fall);

  ////////////////////////////////////////////////////////////////////////
  // input path

  logic in_q;
  logic dual_edge_io_rise;
  logic dual_edge_io_fall;
  logic user_mode;
  logic in_path;
  logic bypass_active;

  assign user_mode     = !configuring_in && pin_used;
  assign in_path       = mode == MODE_INPUT || mode == MODE_BIDIR;
  assign bypass_active = user_mode && mode == MODE_INPUT && bypass;

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      in_q <= 1'b0;
    end else if (in_hit) begin
      in_q <= pad_in;
    end
  end

  dual_edge_io u_dual_edge_io_in (
    .clk_in     (ref_clk_in),
    .rst_n_in   (rst_n),
    .rise_in    (cap_rise),
    .fall_in    (cap_fall),
    .d_in       (pad_in),
    .resync_in  (resync),
    .q_rise_out (dual_edge_io_rise),
    .q_fall_out (dual_edge_io_fall)
  );

  logic [1:0] next_core_in;

  always_comb begin
    next_core_in = 2'h0;
    if (user_mode && in_path && !bypass_active) begin
      if (dual_edge_io_in && mode == MODE_INPUT) begin
        next_core_in = {dual_edge_io_fall, dual_edge_io_rise};
      end else begin
        next_core_in = {1'b0, in_reg ? in_q : pad_in};
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      core_in_out <= 2'h0;
    end else begin
      core_in_out <= next_core_in;
    end
  end

  // unregistered on purpose, also the pll reference source
  assign bypass_path_out = bypass_active && pad_in;

  ////////////////////////////////////////////////////////////////////////
  // output and output-enable paths

  logic out_q;
  logic oe_q;
  logic out_val;
  logic drive;
  logic oe_val;

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= 1'b0;
    end else if (dual_edge_io_out && lau_rise) begin
      out_q <= core_out_in[0];
    end else if (dual_edge_io_out && lau_fall) begin
      out_q <= core_out_in[1];
    end else if (!dual_edge_io_out && out_hit) begin
      out_q <= core_out_in[0];
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      oe_q <= 1'b0;
    end else if (oe_hit) begin
      oe_q <= core_oe_in;
    end
  end

  assign out_val = (out_reg || dual_edge_io_out) ? out_q : core_out_in[0];
  assign drive   = out_val ^ invert;
  assign oe_val  = oe_reg ? oe_q : core_oe_in;

  logic next_pad;
  logic next_oe;

  always_comb begin
    next_pad = 1'b0;
    next_oe  = 1'b0;
    if (user_mode) begin
      case (mode)
        MODE_OUTPUT: begin
          next_oe  = 1'b1;
          next_pad = drive;
        end
        MODE_BIDIR: begin
          next_oe  = oe_val;
          next_pad = oe_val && drive;
        end
        MODE_CLKOUT: begin
          next_oe  = 1'b1;
          next_pad = clock_tree_in;
        end
        default: begin
          next_oe  = 1'b0;
          next_pad = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pad_out    <= 1'b0;
      pad_oe_out <= 1'b0;
    end else begin
      pad_out    <= next_pad;
      pad_oe_out <= next_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // weak pulls

  logic next_pull_up;
  logic next_pull_down;

  always_comb begin
    next_pull_up   = 1'b0;
    next_pull_down = 1'b0;
    if (configuring_in) begin
      next_pull_up = !diff_pair;
    end else if (!pin_used) begin
      next_pull_up   = !pd_sel;
      next_pull_down = pd_sel && !diff_pair;
    end
  end

  // registered pulls keep a held pull-up free of glitches
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pull_up_out   <= 1'b1;
      pull_down_out <= 1'b0;
    end else begin
      pull_up_out   <= next_pull_up;
      pull_down_out <= next_pull_down;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n);

  logic plain_in;
  logic plain_out;
  logic ddo_live;

  assign plain_in  = user_mode && mode == MODE_INPUT && !bypass && !dual_edge_io_in;
  assign plain_out = user_mode && mode == MODE_OUTPUT && !out_reg
                     && !dual_edge_io_out;
  assign ddo_live  = user_mode && mode == MODE_OUTPUT && dual_edge_io_out;

  sequence s_in_held;
    (in_reg && plain_in && !in_hit && $stable(ctrl)) [*2];
  endsequence

  sequence s_bidir_capture;
    (user_mode && mode == MODE_BIDIR && in_reg && in_hit)
    ##1 (user_mode && mode == MODE_BIDIR && in_reg && $stable(ctrl)
         && !in_hit);
  endsequence

  sequence s_ddo_fall;
    (ddo_live && lau_fall && $stable(ctrl))
    ##1 (ddo_live && $stable(ctrl) && !lau_rise && !lau_fall);
  endsequence

  AST_IN_PASS: assert property (
    (plain_in && !in_reg) |=> core_in_out == {1'b0, $past(pad_in)})
    else $error("unregistered input not passed through");

  AST_IN_HOLD: assert property (
    s_in_held |=> $stable(core_in_out))
    else $error("input register changed without edge");

  AST_BYPASS_CORE: assert property (
    bypass_active |=> core_in_out == 2'h0)
    else $error("bypass pin leaked into core path");

  AST_BYPASS_REF: assert property (
    (bypass_active && $rose(pad_in)) |-> bypass_path_out)
    else $error("bypass path did not follow pad");

  AST_OUT_PASS: assert property (
    plain_out |=> pad_oe_out
                  && pad_out == ($past(core_out_in[0]) ^ $past(invert)))
    else $error("output value or inversion wrong");

  AST_DUAL_EDGE_IO_OUT_FALL: assert property (
    s_ddo_fall |=> pad_out == ($past(core_out_in[1], 2) ^ $past(invert)))
    else $error("falling output bit not launched");

  AST_BIDIR_IN: assert property (
    s_bidir_capture |=> core_in_out[0] == $past(pad_in, 2))
    else $error("bidir input register not captured");

  AST_OE_OFF: assert property (
    (user_mode && mode == MODE_BIDIR && !oe_reg && !core_oe_in)
    |=> !pad_oe_out && !pad_out)
    else $error("pad driven while enable low");

  AST_CLKOUT: assert property (
    (user_mode && mode == MODE_CLKOUT)
    |=> pad_oe_out && pad_out == $past(clock_tree_in))
    else $error("clock tree not on pad");

  AST_CFG_PULL: assert property (
    configuring_in |=> !pad_oe_out && !pull_down_out
                       && pull_up_out == !$past(diff_pair))
    else $error("pull during configuration wrong");

  AST_USER_PULL: assert property (
    (!configuring_in && !pin_used) |=> !pad_oe_out
      && pull_up_out == !$past(pd_sel)
      && pull_down_out == ($past(pd_sel) && !$past(diff_pair)))
    else $error("unused pin pull wrong");

  AST_NO_GLITCH: assert property (
    (configuring_in && !diff_pair && !pd_sel && !pin_used)
    ##1 (!configuring_in && $stable(ctrl)) |-> pull_up_out [*2])
    else $error("pull-up dropped entering user mode");

endmodule

`default_nettype wire

/* core/pad_io_map.svh */
// register offsets, field positions and reset values of the pad cell
`ifndef PAD_IO_MAP_SVH
`define PAD_IO_MAP_SVH

`define PIO_CTRL_ADDR      8'h00
`define PIO_STAT_ADDR      8'h04

`define PIO_CTRL_WIDTH     16
`define PIO_CTRL_RESET     16'h0000

`define PIO_MODE_LSB       0
`define PIO_MODE_MSB       1
`define PIO_IN_REG_BIT     2
`define PIO_IN_FALL_BIT    3
`define PIO_OUT_REG_BIT    4
`define PIO_OUT_FALL_BIT   5
`define PIO_OE_REG_BIT     6
`define PIO_OE_FALL_BIT    7
`define PIO_INVERT_BIT     8
`define PIO_DUAL_EDGE_IO_IN_BIT    9
`define PIO_DUAL_EDGE_IO_OUT_BIT   10
`define PIO_RESYNC_BIT     11
`define PIO_BYPASS_BIT     12
`define PIO_PULL_DOWN_BIT  13
`define PIO_DIFF_PAIR_BIT  14
`define PIO_USED_BIT       15

`define PIO_STAT_PAD_BIT   0
`define PIO_STAT_CORE_LSB  1
`define PIO_STAT_OE_BIT    3
`define PIO_STAT_OUT_BIT   4
`define PIO_STAT_CFG_BIT   5
`define PIO_STAT_WIDTH     6

`endif

/* core/pad_io_pkg.sv */
// types and helpers shared by the pad cell modules
package pad_io_pkg;

  typedef enum logic [1:0] {
    MODE_INPUT,
    MODE_OUTPUT,
    MODE_BIDIR,
    MODE_CLKOUT
  } pad_mode_e;

  // select the strobe of the chosen clock edge
  function automatic logic pick_edge(input logic rise,
                                     input logic fall,
                                     input logic use_fall);
    return use_fall ? fall : rise;
  endfunction

endpackage

/* core/dual_edge_io.sv */
// dual-edge input capture with optional resync to the rising edge
`timescale 1ns/1ps
`default_nettype none

module dual_edge_io (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic rise_in,
  input  wire logic fall_in,
  input  wire logic d_in,
  input  wire logic resync_in,
  output logic      q_rise_out,
  output logic      q_fall_out
);

  logic hi;
  logic lo_raw;
  logic lo_sync;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hi <= 1'b0;
    end else if (rise_in) begin
      hi <= d_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lo_raw <= 1'b0;
    end else if (fall_in) begin
      lo_raw <= d_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lo_sync <= 1'b0;
    end else if (rise_in) begin
      lo_sync <= lo_raw;
    end
  end

  assign q_rise_out = hi;
  assign q_fall_out = resync_in ? lo_sync : lo_raw;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  logic fall_pad;

  // last pad level seen at a falling capture edge
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fall_pad <= 1'b0;
    end else if (fall_in) begin
      fall_pad <= d_in;
    end
  end

  sequence s_resync_rise;
    (resync_in && rise_in) ##1 resync_in;
  endsequence

  AST_RISE_SAMPLE: assert property (
    rise_in |=> q_rise_out == $past(d_in))
    else $error("rising sample not captured");

  AST_RESYNC_HALF: assert property (
    s_resync_rise |-> q_fall_out == $past(fall_pad))
    else $error("falling sample not resynced");

endmodule

`default_nettype wire

/* verif/core_fabric_model.sv */
// core fabric model: clocks and user data toward the pad cell
`timescale 1ns/1ps
`default_nettype none

module core_fabric_model #(
  parameter int HALF = 6
) (
  input  wire logic       ref_clk_in,
  input  wire logic [1:0] want_out_in,
  input  wire logic       want_oe_in,
  output logic            capture_clock_out,
  output logic            launch_clock_out,
  output logic            clock_tree_out,
  output logic      [1:0] core_out_out,
  output logic            core_oe_out
);
  int cnt;

  initial begin
    cnt = 0;
    capture_clock_out = 1'b0;
    launch_clock_out = 1'b0;
    clock_tree_out = 1'b0;
    core_out_out = 2'h0;
    core_oe_out = 1'b0;
  end

  // slow user clocks, tree toggles every cycle, data registered
  always @(posedge ref_clk_in) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) begin
      capture_clock_out <= ~capture_clock_out;
      launch_clock_out <= ~launch_clock_out;
    end
    clock_tree_out <= ~clock_tree_out;
    core_out_out <= want_out_in;
    core_oe_out <= want_oe_in;
  end
endmodule
`default_nettype wire

/* verif/testbench.sv */
// self-checking bench for the pad cell
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin bad_count++; \
  $display("ERROR %0t got %h exp %h", $time, a, e); end end

module testbench;
  logic        clk, rstn, wr, rd, cfg, pad, want_oe, coe, tree, capc, lnc;
  logic        byp, pado, padoe, pu, pd, prev;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata;
  logic [1:0]  want_out, cout, cin;
  int          bad_count, n_compared;

  pad_io_register_cell DUT (
    .ref_clk_in(clk), .rstn_in(rstn), .bus_addr_in(addr),
    .bus_wdata_in(wdata), .bus_write_in(wr), .bus_read_in(rd),
    .bus_rdata_out(rdata), .configuring_in(cfg), .capture_clock_in(capc),
    .launch_clock_in(lnc), .clock_tree_in(tree), .core_out_in(cout),
    .core_oe_in(coe), .core_in_out(cin), .bypass_path_out(byp),
    .pad_in(pad), .pad_out(pado), .pad_oe_out(padoe),
    .pull_up_out(pu), .pull_down_out(pd)
  );

  core_fabric_model #(.HALF(6)) partner (
    .ref_clk_in(clk), .want_out_in(want_out), .want_oe_in(want_oe),
    .capture_clock_out(capc), .launch_clock_out(lnc),
    .clock_tree_out(tree), .core_out_out(cout), .core_oe_out(coe)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    if (bad_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic setp(input logic v);
    @(posedge clk) pad <= v;
  endtask

  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk) begin
      wr <= 1'b1;
      addr <= a;
      wdata <= {16'h0000, d};
    end
    @(posedge clk) wr <= 1'b0;
    step(3);
  endtask

  task automatic rreg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk) begin
      rd <= 1'b1;
      addr <= a;
    end
    @(posedge clk) rd <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask

  // pad low at the rise sample, high at the fall sample
  task automatic ddi(input logic [15:0] c, input logic [1:0] e);
    wreg(8'h00, c);
    setp(1'b0);
    step(14);
    @(posedge capc);
    repeat (3) @(posedge clk);
    pad <= 1'b1;
    @(negedge capc);
    repeat (2) @(posedge clk);
    pad <= 1'b0;
    step(1);
    `CHK(cin, e)
    @(posedge capc);
    step(4);
    `CHK(cin, 2'h2)
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    bad_count++;
    report_and_stop();
  end

  initial begin
    {wr, rd, cfg, pad, want_oe} = 5'h00;
    {rstn, addr, wdata, want_out} = '0;
    bad_count = 0;
    n_compared = 0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    step(4);
    `CHK(pu, 1'b1)
    `CHK(padoe, 1'b0)
    rreg(8'h00, 32'h0000_0000);
    @(posedge clk) cfg <= 1'b1;
    wreg(8'h00, 16'h4000);
    `CHK({pu, pd}, 2'h0)
    wreg(8'h00, 16'h0000);
    `CHK({pu, pd}, 2'h2)
    wreg(8'h04, 16'hFFFF);
    rreg(8'h04, 32'h0000_0020);
    wreg(8'h08, 16'hFFFF);
    rreg(8'h08, 32'h0000_0000);
    rreg(8'h00, 32'h0000_0000);
    @(posedge clk) cfg <= 1'b0;
    repeat (4) begin
      step(1);
      `CHK(pu, 1'b1)
    end
    wreg(8'h00, 16'h2000);
    `CHK({pu, pd}, 2'h1)
    wreg(8'h00, 16'h6000);
    `CHK(pd, 1'b0)
    want_out <= 2'h1;
    setp(1'b1);
    wreg(8'h00, 16'h8001);
    `CHK({pado, padoe, pu, pd}, 4'hC)
    `CHK(cin, 2'h0)
    wreg(8'h00, 16'h8101);
    `CHK(pado, 1'b0)
    want_oe <= 1'b1;
    wreg(8'h00, 16'h8002);
    `CHK({pado, padoe}, 2'h3)
    `CHK(cin[0], 1'b1)
    wreg(8'h00, 16'h8102);
    `CHK(pado, 1'b0)
    @(posedge clk) want_oe <= 1'b0;
    setp(1'b0);
    step(4);
    `CHK(padoe, 1'b0)
    `CHK(cin[0], 1'b0)
    wreg(8'h00, 16'h8003);
    repeat (6) begin
      prev = tree;
      step(1);
      `CHK(pado, prev)
    end
    wreg(8'h00, 16'h8000);
    setp(1'b1);
    step(3);
    `CHK({padoe, cin}, 3'h1)
    wreg(8'h00, 16'h9000);
    `CHK(cin, 2'h0)
    setp(1'b0);
    #1;
    `CHK(byp, 1'b0)
    setp(1'b1);
    #1;
    `CHK(byp, 1'b1)
    wreg(8'h00, 16'h8004);
    setp(1'b0);
    @(posedge capc);
    repeat (3) @(posedge clk);
    pad <= 1'b1;
    step(4);
    `CHK(cin[0], 1'b0)
    @(posedge capc);
    step(4);
    `CHK(cin[0], 1'b1)
    wreg(8'h00, 16'h800C);
    @(negedge capc);
    repeat (3) @(posedge clk);
    pad <= 1'b0;
    step(4);
    `CHK(cin[0], 1'b1)
    @(negedge capc);
    step(4);
    `CHK(cin[0], 1'b0)
    wreg(8'h00, 16'h8006);
    @(posedge capc);
    repeat (3) @(posedge clk);
    pad <= 1'b1;
    step(4);
    `CHK(cin[0], 1'b0)
    @(posedge capc);
    step(4);
    `CHK(cin[0], 1'b1)
    ddi(16'h8200, 2'h2);
    ddi(16'h8A00, 2'h0);
    wreg(8'h00, 16'h8011);
    @(posedge lnc);
    repeat (3) @(posedge clk);
    want_out <= 2'h2;
    step(4);
    `CHK(pado, 1'b1)
    @(posedge lnc);
    step(4);
    `CHK(pado, 1'b0)
    wreg(8'h00, 16'h80C2);
    @(negedge lnc);
    repeat (3) @(posedge clk);
    want_oe <= 1'b1;
    step(4);
    `CHK(padoe, 1'b0)
    @(negedge lnc);
    step(4);
    `CHK(padoe, 1'b1)
    @(posedge clk) want_out <= 2'h2;
    wreg(8'h00, 16'h8401);
    @(negedge lnc);
    step(4);
    `CHK(pado, 1'b1)
    @(posedge lnc);
    step(4);
    `CHK(pado, 1'b0)
    report_and_stop();
  end
endmodule
`default_nettype wire
